// >>> logic/mad_consts.svh
// Constants for the motion alarm detector: offsets, fields, reset values, timing
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH
`define MAD_CLK_HZ 20000000
`define MAD_MS_CYCLES (`MAD_CLK_HZ / 1000)
`define MAD_OFF_CTRL 12'h000
`define MAD_OFF_SENS 12'h004
`define MAD_OFF_THRESH 12'h008
`define MAD_OFF_LIMIT 12'h00C
`define MAD_OFF_ON_DLY 12'h010
`define MAD_OFF_OFF_DLY 12'h014
`define MAD_OFF_CMD 12'h018
`define MAD_OFF_STATUS 12'h01C
`define MAD_OFF_LEVEL 12'h020
`define MAD_OFF_BUFCFG 12'h024
`define MAD_BIT_MODE 0
`define MAD_BIT_SHOW 1
`define MAD_BIT_SRC_USER 2
`define MAD_BIT_SRC_DIN 3
`define MAD_BIT_SRC_MOT 4
`define MAD_POS_HIST 8
`define MAD_POS_GRAN 16
`define MAD_RST_CTRL 32'h0002_0500
`define MAD_RST_SENS 32'h0000_0014
`define MAD_RST_THRESH 32'h0000_03E8
`define MAD_RST_LIMIT 32'h0001_3880
`define MAD_RST_BUFCFG 32'h0000_0000
`define MAD_CMD_TRIG 0
`define MAD_CMD_ARM 1
`define MAD_CMD_DIS 4
`define MAD_HIST_MAX 8
`define MAD_NSTREAM 3
`endif

// >>> logic/mad_motion_alarm_detector.sv
// Motion detector, alarm source logic and stream alarm buffer control
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "mad_consts.svh"

module mad_motion_alarm_detector #(
    parameter int PIXELS = 1024,
    parameter int HIST_MAX = `MAD_HIST_MAX
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mad_pkg::mad_pix_s pix_in,
    output mad_pkg::mad_mark_s pix_out,
    input wire logic [`MAD_NSTREAM-1:0] stream_frame,
    output logic [`MAD_NSTREAM-1:0] buf_write,
    output logic [`MAD_NSTREAM-1:0] buf_ring_clear,
    input wire logic dig_in,
    output logic alarm,
    output logic motion
);
    localparam int AW = $clog2(PIXELS);
    localparam int HW = $clog2(HIST_MAX);

    // Registers
    logic [31:0] ctrl, sens, thresh, limit, on_dly, off_dly, bufcfg;
    logic [31:0] level;
    mad_pkg::mad_buf_e st [`MAD_NSTREAM];

    wire mode_on = ctrl[`MAD_BIT_MODE];
    wire show_on = ctrl[`MAD_BIT_SHOW];
    wire [3:0] hist_n = (ctrl[`MAD_POS_HIST +: 4] == 4'h0) ? 4'h1 :
        (ctrl[`MAD_POS_HIST +: 4] > 4'(HIST_MAX)) ? 4'(HIST_MAX) : ctrl[`MAD_POS_HIST +: 4];
    wire [7:0] gran = (ctrl[`MAD_POS_GRAN +: 8] == 8'h00) ? 8'h01 : ctrl[`MAD_POS_GRAN +: 8];

    // AXI write channel: address and data taken in either order
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire [11:0] wr_a = aw_addr;
    logic cmd_stb;
    logic [31:0] cmd_val;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    function automatic logic [31:0] ms_to_cyc(input logic [31:0] ms);
        return 32'(ms * `MAD_MS_CYCLES);
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl <= `MAD_RST_CTRL;
            sens <= `MAD_RST_SENS;
            thresh <= `MAD_RST_THRESH;
            limit <= `MAD_RST_LIMIT;
            on_dly <= 32'h0000_0000;
            off_dly <= 32'h0000_0000;
            bufcfg <= `MAD_RST_BUFCFG;
            cmd_stb <= 1'b0;
            cmd_val <= 32'h0000_0000;
        end
        else
        begin
            cmd_stb <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (wr_a)
                    `MAD_OFF_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
                    `MAD_OFF_SENS: sens <= merge(sens, w_data, w_strb);
                    `MAD_OFF_THRESH: thresh <= merge(thresh, w_data, w_strb);
                    `MAD_OFF_LIMIT: limit <= merge(limit, w_data, w_strb);
                    `MAD_OFF_ON_DLY: on_dly <= merge(on_dly, w_data, w_strb);
                    `MAD_OFF_OFF_DLY: off_dly <= merge(off_dly, w_data, w_strb);
                    `MAD_OFF_BUFCFG: bufcfg <= merge(bufcfg, w_data, w_strb);
                    `MAD_OFF_CMD:
                    begin
                        cmd_stb <= 1'b1;
                        cmd_val <= merge(32'h0000_0000, w_data, w_strb);
                    end
                    `MAD_OFF_STATUS, `MAD_OFF_LEVEL: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    // AXI read channel
    wire [31:0] status_word = {20'h0_0000, motion, alarm, 1'b0, st[2], st[1], st[0]};
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `MAD_OFF_CTRL: rd_mux = ctrl;
            `MAD_OFF_SENS: rd_mux = sens;
            `MAD_OFF_THRESH: rd_mux = thresh;
            `MAD_OFF_LIMIT: rd_mux = limit;
            `MAD_OFF_ON_DLY: rd_mux = on_dly;
            `MAD_OFF_OFF_DLY: rd_mux = off_dly;
            `MAD_OFF_CMD: rd_mux = 32'h0000_0000;
            `MAD_OFF_STATUS: rd_mux = status_word;
            `MAD_OFF_LEVEL: rd_mux = level;
            `MAD_OFF_BUFCFG: rd_mux = bufcfg;
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Frame store and history average
    logic [7:0] fmem [HIST_MAX][PIXELS];
    logic [AW-1:0] pidx;
    logic [HW-1:0] wslot;
    logic [7:0] gcnt;
    logic [31:0] chg_cnt;
    logic [HW:0] filled;
    wire [AW-1:0] pos = pix_in.sof ? AW'(0) : pidx;

    logic [11:0] hsum;
    always_comb
    begin
        hsum = 12'h000;
        for (int k = 0; k < HIST_MAX; k++)
            if (k < int'(hist_n) && k < int'(filled))
                hsum = hsum + 12'(fmem[(int'(wslot) + HIST_MAX - 1 - k) % HIST_MAX][pos]);
    end
    wire [3:0] hdiv = (filled == '0) ? 4'h1 :
        ((HW+1)'(hist_n) < filled) ? hist_n : 4'(filled);
    wire [7:0] hist_pix = 8'(hsum / 12'(hdiv));
    wire [7:0] diff = (pix_in.pix > hist_pix) ? pix_in.pix - hist_pix : hist_pix - pix_in.pix;
    wire pix_pos = pix_in.sof ? 1'b1 : (gcnt == gran - 8'h01);
    wire cmp_en = mode_on && filled != '0 && pix_pos;
    wire changed = cmp_en && (32'(diff) * 32'd100 >= 32'(hist_pix) * sens);
    wire [31:0] frame_cnt = chg_cnt + 32'(changed);
    wire frame_motion = (frame_cnt > thresh) && (frame_cnt < limit);

    always_ff @(posedge aclk)
    begin
        if (pix_in.valid)
            fmem[wslot][pos] <= pix_in.pix;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pidx <= '0;
            wslot <= '0;
            gcnt <= 8'h00;
            chg_cnt <= 32'h0000_0000;
            filled <= '0;
            level <= 32'h0000_0000;
            motion <= 1'b0;
            pix_out <= '0;
        end
        else
        begin
            pix_out.valid <= pix_in.valid;
            pix_out.sof <= pix_in.sof;
            pix_out.pix <= pix_in.pix;
            pix_out.green <= pix_in.valid && show_on && changed;
            if (pix_in.valid)
            begin
                pidx <= pix_in.sof ? AW'(1) : pidx + AW'(1);
                gcnt <= pix_pos ? 8'h00 : gcnt + 8'h01;
                chg_cnt <= pix_in.sof ? 32'(changed) : frame_cnt;
                if (pix_in.eof)
                begin
                    level <= frame_cnt;
                    motion <= mode_on && frame_motion;
                    wslot <= (wslot == HW'(HIST_MAX - 1)) ? '0 : wslot + HW'(1);
                    if (filled < (HW+1)'(HIST_MAX))
                        filled <= filled + (HW+1)'(1);
                end
            end
        end
    end

    // Motion debounce
    logic [31:0] dcnt;
    logic mot_alarm;
    wire [31:0] dly_cyc = ms_to_cyc(mot_alarm ? off_dly : on_dly);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dcnt <= 32'h0000_0000;
            mot_alarm <= 1'b0;
        end
        else if (motion == mot_alarm)
            dcnt <= 32'h0000_0000;
        else if (dcnt >= dly_cyc)
        begin
            mot_alarm <= motion;
            dcnt <= 32'h0000_0000;
        end
        else
            dcnt <= dcnt + 32'h0000_0001;
    end

    // Alarm sources
    logic din_s1, din_s2, din_s3;
    wire din_rise = din_s2 && !din_s3;
    wire user_trig = cmd_stb && cmd_val[`MAD_CMD_TRIG] && ctrl[`MAD_BIT_SRC_USER];
    wire din_trig = din_rise && ctrl[`MAD_BIT_SRC_DIN];
    wire mot_trig = mot_alarm && mode_on && ctrl[`MAD_BIT_SRC_MOT];
    wire next_alarm = user_trig || din_trig || mot_trig;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            din_s3 <= 1'b0;
            alarm <= 1'b0;
        end
        else
        begin
            din_s1 <= dig_in;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            alarm <= next_alarm;
        end
    end

    // Per-stream alarm buffers
    for (genvar s = 0; s < `MAD_NSTREAM; s++)
    begin : g_buf
        wire [4:0] tot = bufcfg[s*10 +: 5];
        wire [4:0] post = bufcfg[s*10 + 5 +: 5];
        wire arm_cmd = cmd_stb && cmd_val[`MAD_CMD_ARM + s];
        wire dis_cmd = cmd_stb && cmd_val[`MAD_CMD_DIS + s];
        wire arm_ok = arm_cmd && tot != 5'h00 && post != 5'h00;
        logic [4:0] pcnt;
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                st[s] <= mad_pkg::MAD_OFF;
                pcnt <= 5'h00;
                buf_write[s] <= 1'b0;
                buf_ring_clear[s] <= 1'b0;
            end
            else
            begin
                buf_write[s] <= 1'b0;
                buf_ring_clear[s] <= 1'b0;
                if (dis_cmd)
                    st[s] <= mad_pkg::MAD_OFF;
                else if (arm_ok)
                begin
                    st[s] <= mad_pkg::MAD_ARMING;
                    buf_ring_clear[s] <= 1'b1;
                end
                else
                    case (st[s])
                        mad_pkg::MAD_OFF: st[s] <= mad_pkg::MAD_OFF;
                        mad_pkg::MAD_ARMING: st[s] <= mad_pkg::MAD_ARMED;
                        mad_pkg::MAD_ARMED:
                        begin
                            buf_write[s] <= stream_frame[s];
                            if (alarm)
                            begin
                                st[s] <= mad_pkg::MAD_ACTIVE;
                                pcnt <= 5'h00;
                            end
                        end
                        mad_pkg::MAD_ACTIVE:
                            if (stream_frame[s])
                            begin
                                buf_write[s] <= 1'b1;
                                pcnt <= pcnt + 5'h01;
                                if (pcnt + 5'h01 >= post)
                                    st[s] <= mad_pkg::MAD_DONE;
                            end
                        mad_pkg::MAD_DONE: st[s] <= mad_pkg::MAD_DONE;
                        default: st[s] <= mad_pkg::MAD_OFF;
                    endcase
            end
        end
    end
endmodule

// >>> logic/mad_pkg.sv
// Types for the motion alarm detector
package mad_pkg;
    typedef enum logic [2:0] {MAD_OFF, MAD_ARMING, MAD_ARMED, MAD_ACTIVE, MAD_DONE} mad_buf_e;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] pix;
    } mad_pix_s;
    typedef struct packed {
        logic valid;
        logic sof;
        logic [7:0] pix;
        logic green;
    } mad_mark_s;
endpackage

// >>> test/mad_capture_model.sv
// Capture pipeline model: pixels, frame strobes, input line
`timescale 1ns/1ns
module mad_capture_model #(
    parameter int PIXELS = 16
) (
    input wire logic aclk,
    output mad_pkg::mad_pix_s pix_in,
    output logic [2:0] stream_frame,
    output logic dig_in
);
    initial
    begin
        pix_in = '0;
        stream_frame = '0;
        dig_in = 1'b0;
    end
    // One frame: first nb pixels b, rest a
    task automatic frame(input logic [7:0] a, input logic [7:0] b, input int nb);
        for (int i = 0; i < PIXELS; i++)
        begin
            @(posedge aclk);
            pix_in <= '{1'b1, i == 0, i == PIXELS - 1, i < nb ? b : a};
        end
        @(posedge aclk);
        pix_in <= '{1'b0, 1'b0, 1'b0, ~pix_in.pix};
    endtask
    task automatic capture(input logic [2:0] s);
        @(posedge aclk);
        stream_frame <= s;
        @(posedge aclk);
        stream_frame <= '0;
    endtask
    task automatic line(input logic v);
        @(posedge aclk);
        dig_in <= v;
    endtask
endmodule

// >>> test/mad_checker.sv
// Port assertions for the motion alarm detector
`timescale 1ns/1ns
module mad_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mad_pkg::mad_pix_s pix_in,
    input wire mad_pkg::mad_mark_s pix_out,
    input wire logic [2:0] stream_frame,
    input wire logic [2:0] buf_write,
    input wire logic [2:0] buf_ring_clear,
    input wire logic motion
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_pix_copy: assert property (
        pix_in.valid |=> pix_out.valid && pix_out.pix == $past(pix_in.pix))
        else $error("pixel copy");
    chk_green_valid: assert property (
        pix_out.green |-> pix_out.valid)
        else $error("stray green");
    chk_motion_frame: assert property (
        $changed(motion) |-> $past(pix_in.eof) || $past(pix_in.eof, 2) || $past(pix_in.eof, 3))
        else $error("motion off frame end");
    chk_write_frame: assert property (
        (buf_write & ~$past(stream_frame)) == 3'h0)
        else $error("write without frame");
    chk_clear_pulse: assert property (
        buf_ring_clear != 3'h0 |=> buf_ring_clear == 3'h0)
        else $error("clear too long");
    chk_clear_cmd: assert property (
        buf_ring_clear != 3'h0 |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
            || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4))
        else $error("clear without command");
    chk_bresp_once: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("double response");
    chk_rdata_once: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("double read data");
endmodule

bind mad_motion_alarm_detector mad_checker chk (.aclk, .aresetn, .s_axi_wvalid, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .pix_in, .pix_out, .stream_frame, .buf_write,
    .buf_ring_clear, .motion);

// >>> test/testbench.sv
// Self-checking bench for the motion alarm detector
`timescale 1ns/1ns
`include "mad_consts.svh"
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("ERROR %0t: got %0h want %0h", $time, g, e); \
        end \
    end
module testbench;
    localparam int PIX = 16;
    localparam logic [11:0] CT = `MAD_OFF_CTRL;
    localparam logic [11:0] CM = `MAD_OFF_CMD;
    localparam logic [11:0] ST = `MAD_OFF_STATUS;
    localparam logic [11:0] LV = `MAD_OFF_LEVEL;
    localparam logic [31:0] MODE = 32'h1 << `MAD_BIT_MODE;
    localparam logic [31:0] USR = 32'h1 << `MAD_BIT_SRC_USER;
    localparam logic [31:0] DIN = 32'h1 << `MAD_BIT_SRC_DIN;
    localparam logic [31:0] MOT = 32'h1 << `MAD_BIT_SRC_MOT;
    localparam logic [31:0] H1G1 = 32'h0001_0100;
    logic aclk = 1'b0;
    logic aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] stream_frame, buf_write, buf_ring_clear;
    logic dig_in, alarm, motion;
    mad_pkg::mad_pix_s pix_in;
    mad_pkg::mad_mark_s pix_out;
    int num_errors = 0;
    int checks = 0;
    int hits = 0;
    int wcnt = 0;
    int gcnt = 0;
    always #25 aclk = ~aclk;
    always @(posedge aclk)
    begin
        hits <= hits + int'(alarm);
        wcnt <= wcnt + $countones(buf_write);
        gcnt <= gcnt + int'(pix_out.valid && pix_out.green);
    end
    mad_motion_alarm_detector #(.PIXELS(PIX)) dut (.*);
    mad_capture_model #(.PIXELS(PIX)) cap (.aclk, .pix_in, .stream_frame, .dig_in);
    task automatic close_out();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100)
        begin
            $display("ERROR %0t: timeout", $time);
            num_errors++;
            close_out();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF,
        input logic [1:0] e = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= b;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            step(n);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid);
        `CHK(s_axi_bresp, e)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1,
        input logic [1:0] r = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            step(n);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_arvalid || !s_axi_rvalid);
        `CHK(s_axi_rdata & m, e)
        `CHK(s_axi_rresp, r)
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_src();
        int h;
        h = hits;
        rd(CT, `MAD_RST_CTRL);
        rd(12'h100, 32'h0, '1, 2'h2);
        wr(`MAD_OFF_SENS, 32'hFFFF_FF14, 4'h1);
        rd(`MAD_OFF_SENS, `MAD_RST_SENS);
        rd(`MAD_OFF_THRESH, `MAD_RST_THRESH);
        wr(CM, 32'h1);
        cap.line(1'b1);
        repeat (8) @(posedge aclk);
        `CHK(hits, h)
        cap.line(1'b0);
        wr(CT, USR | DIN);
        wr(CM, 32'h1);
        repeat (4) @(posedge aclk);
        `CHK(hits > h, 1'b1)
        h = hits;
        cap.line(1'b1);
        repeat (8) @(posedge aclk);
        `CHK(hits > h, 1'b1)
        cap.line(1'b0);
    endtask
    task automatic t_buf();
        int w;
        rd(ST, 32'h0, 32'h1FF);
        wr(CM, 32'hE);
        rd(ST, 32'h0, 32'h1FF);
        wr(`MAD_OFF_BUFCFG, 32'h0481_2048);
        wr(CM, 32'hE);
        rd(ST, 32'h092, 32'h1FF);
        w = wcnt;
        cap.capture(3'h7);
        repeat (4) @(posedge aclk);
        `CHK(wcnt - w, 3)
        wr(CT, USR);
        wr(CM, 32'h1);
        rd(ST, 32'h0DB, 32'h1FF);
        cap.capture(3'h7);
        cap.capture(3'h7);
        repeat (4) @(posedge aclk);
        rd(ST, 32'h124, 32'h1FF);
        w = wcnt;
        cap.capture(3'h7);
        repeat (4) @(posedge aclk);
        `CHK(wcnt, w)
        wr(CM, 32'h4);
        rd(ST, 32'h114, 32'h1FF);
        wr(CM, 32'h52);
        rd(ST, 32'h010, 32'h1FF);
    endtask
    task automatic t_gran();
        int g0;
        for (int g = 1; g <= 3; g++)
        begin
            wr(CT, MODE | 32'h2 | 32'h100 | (g << `MAD_POS_GRAN));
            cap.frame(8'h64, 8'h64, 0);
            repeat (2) @(posedge aclk);
            g0 = gcnt;
            cap.frame(8'h64, 8'hC8, PIX);
            repeat (6) @(posedge aclk);
            rd(LV, (PIX + g - 1) / g);
            `CHK(gcnt - g0, (PIX + g - 1) / g)
        end
    endtask
    task automatic t_pix();
        wr(CT, MODE | 32'h0001_0200);
        cap.frame(8'h64, 8'h64, 0);
        cap.frame(8'h64, 8'h64, 0);
        cap.frame(8'hC8, 8'hC8, 0);
        repeat (6) @(posedge aclk);
        rd(LV, PIX);
        cap.frame(8'h96, 8'h96, 0);
        repeat (6) @(posedge aclk);
        rd(LV, 32'h0);
        wr(CT, MODE | H1G1);
        cap.frame(8'h64, 8'h64, 0);
        cap.frame(8'h64, 8'h77, 6);
        repeat (6) @(posedge aclk);
        rd(LV, 32'h0);
        cap.frame(8'h64, 8'h64, 0);
        cap.frame(8'h64, 8'h78, 6);
        repeat (6) @(posedge aclk);
        rd(LV, 32'h6);
    endtask
    task automatic t_motion();
        int n[4] = '{4, 5, 9, 10};
        wr(`MAD_OFF_THRESH, 32'h4);
        wr(`MAD_OFF_LIMIT, 32'hA);
        wr(`MAD_OFF_ON_DLY, 32'h0);
        wr(`MAD_OFF_OFF_DLY, 32'h0);
        wr(CT, MODE | MOT | H1G1);
        foreach (n[i])
        begin
            cap.frame(8'h64, 8'h64, 0);
            cap.frame(8'h64, 8'hC8, n[i]);
            repeat (6) @(posedge aclk);
            `CHK(motion, n[i] > 4 && n[i] < 10)
            `CHK(alarm, n[i] > 4 && n[i] < 10)
        end
        wr(CT, MOT | H1G1);
        cap.frame(8'h64, 8'h64, 0);
        cap.frame(8'h64, 8'hC8, 5);
        repeat (6) @(posedge aclk);
        `CHK({motion, alarm}, 2'b00)
        wr(`MAD_OFF_ON_DLY, 32'h1);
        wr(`MAD_OFF_OFF_DLY, 32'h1);
        wr(CT, MODE | MOT | H1G1);
        for (int v = 1; v >= 0; v--)
        begin
            cap.frame(8'h64, 8'h64, 0);
            repeat (`MAD_MS_CYCLES - 2) @(posedge aclk);
            `CHK(alarm, !v)
            repeat (8) @(posedge aclk);
            `CHK(alarm, v != 0)
        end
    endtask
    initial
    begin
        aresetn <= 1'b0;
        s_axi_awaddr <= 12'h000;
        s_axi_araddr <= 12'h000;
        s_axi_wdata <= 32'h0000_0000;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_src();
        t_buf();
        t_gran();
        t_pix();
        t_motion();
        close_out();
    end
endmodule
